// ==== hw/bcs_defs.svh ====
`ifndef BCS_DEFS_SVH
`define BCS_DEFS_SVH

// system clock rate in hertz
`define BCS_CLK_HZ 125000000

// times and rates in their own units
`define BCS_TRKL_TIMEOUT_S 1800
`define BCS_SAFETY_S 14400
`define BCS_DEGLITCH_US 1300
`define BCS_PWM_HZ 35000
`define BCS_BLINK_NTC_MHZ 1500
`define BCS_BLINK_BAD_MHZ 6100

// pin-low time in sixteenths of a 35 kHz period
`define BCS_DUTY_NTC_LO 4'h1
`define BCS_DUTY_NTC_HI 4'hf
`define BCS_DUTY_BAD_LO 4'h2
`define BCS_DUTY_BAD_HI 4'he

// counter widths
`define BCS_TIMER_W 42
`define BCS_DEGLITCH_W 18
`define BCS_PWM_W 12
`define BCS_BLINK_W 26

`endif

// ==== hw/bcs_pkg.sv ====
package bcs_pkg;

	typedef enum logic [2:0] {
		BCS_IDLE,
		BCS_TRICKLE,
		BCS_CC,
		BCS_CV,
		BCS_DONE,
		BCS_BAD
	} bcs_state_t;

	typedef enum logic [1:0] {
		BCS_ST_CHARGING,
		BCS_ST_RELEASED,
		BCS_ST_NTC,
		BCS_ST_BAD
	} bcs_status_t;

	// comparator levels from the analog side
	typedef struct packed {
		logic below_trickle;
		logic at_float;
		logic below_recharge;
		logic current_tenth;
		logic input_limited;
		logic vbus_ok;
		logic temp_fault;
	} bcs_sense_t;

	// commands to the analog charge loops
	typedef struct packed {
		logic charge_on;
		logic trickle_current;
		logic voltage_mode;
	} bcs_drive_t;

endpackage

// ==== hw/bcs_dwell_timer.sv ====
`timescale 1ns/10ps
module bcs_dwell_timer #(
	parameter int              W     = 18,
	parameter logic [W-1:0]    LIMIT = '1
) (
	// clock and reset
	input  wire logic          clk_in,
	input  wire logic          rst_in,
	// control
	input  wire logic          clear_in,
	input  wire logic          run_in,
	// state
	output logic [W-1:0]       count_out,
	output logic               expired_out,
	output logic               hit_out
);

	// saturates at the limit so the hit fires once per run
	always_ff @(posedge clk_in) begin
		if (rst_in || clear_in) begin
			count_out <= '0;
		end else if (run_in && count_out != LIMIT) begin
			count_out <= count_out + 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in || clear_in) begin
			hit_out     <= 1'b0;
			expired_out <= 1'b0;
		end else begin
			hit_out     <= run_in && (count_out == LIMIT - 1'b1);
			expired_out <= expired_out || (run_in && (count_out == LIMIT - 1'b1));
		end
	end

endmodule

// ==== hw/bcs_status_pwm.sv ====
`timescale 1ns/10ps
`include "bcs_defs.svh"
module bcs_status_pwm #(
	parameter logic [`BCS_PWM_W-1:0]   PERIOD   = 12'(`BCS_CLK_HZ / `BCS_PWM_HZ),
	parameter logic [`BCS_BLINK_W-1:0] NTC_HALF = 26'h27bc86a,
	parameter logic [`BCS_BLINK_W-1:0] BAD_HALF = 26'h9c580d
) (
	// clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	// indication to show
	input  wire bcs_pkg::bcs_status_t  mode_in,
	// open-drain enable, high pulls the pin low
	output logic                       drive_low_out
);

	logic [`BCS_PWM_W-1:0]   pwm_count;
	logic [`BCS_BLINK_W-1:0] blink_count;
	logic                    blink_high;
	logic [`BCS_BLINK_W-1:0] blink_half;
	logic [3:0]              duty;
	logic [15:0]             low_product;

	assign blink_half  = (mode_in == bcs_pkg::BCS_ST_NTC) ? NTC_HALF : BAD_HALF;
	assign duty        = (mode_in == bcs_pkg::BCS_ST_NTC) ?
		(blink_high ? `BCS_DUTY_NTC_HI : `BCS_DUTY_NTC_LO) :
		(blink_high ? `BCS_DUTY_BAD_HI : `BCS_DUTY_BAD_LO);
	assign low_product = 16'(PERIOD) * 16'(duty);

	always_ff @(posedge clk_in) begin
		if (rst_in || pwm_count == PERIOD - 1'b1) begin
			pwm_count <= '0;
		end else begin
			pwm_count <= pwm_count + 1'b1;
		end
	end

	// equal dim and bright halves of each blink
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			blink_count <= '0;
			blink_high  <= 1'b0;
		end else if (blink_count >= blink_half - 1'b1) begin
			blink_count <= '0;
			blink_high  <= !blink_high;
		end else begin
			blink_count <= blink_count + 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			drive_low_out <= 1'b0;
		end else begin
			unique case (mode_in)
				bcs_pkg::BCS_ST_CHARGING: drive_low_out <= 1'b1;
				bcs_pkg::BCS_ST_RELEASED: drive_low_out <= 1'b0;
				bcs_pkg::BCS_ST_NTC,
				bcs_pkg::BCS_ST_BAD:      drive_low_out <= pwm_count < low_product[15:4];
			endcase
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	ntc_duty_a: assert property (
		(mode_in == bcs_pkg::BCS_ST_NTC && $stable(mode_in) && pwm_count == '0)
		|=> drive_low_out)
		else $error("ntc train not low at period start");

	bad_duty_a: assert property (
		(mode_in == bcs_pkg::BCS_ST_BAD && !blink_high && pwm_count == PERIOD - 1'b1)
		|=> !drive_low_out)
		else $error("bad battery train low at period end");

endmodule

// ==== hw/bcs_charge_sequencer.sv ====
`timescale 1ns/10ps
`include "bcs_defs.svh"
module bcs_charge_sequencer #(
	parameter logic [`BCS_TIMER_W-1:0]    TRKL_CYCLES     =
		42'(64'(`BCS_TRKL_TIMEOUT_S) * 64'(`BCS_CLK_HZ)),
	parameter logic [`BCS_TIMER_W-1:0]    SAFETY_CYCLES   =
		42'(64'(`BCS_SAFETY_S) * 64'(`BCS_CLK_HZ)),
	parameter logic [`BCS_DEGLITCH_W-1:0] DEGLITCH_CYCLES =
		18'((64'(`BCS_DEGLITCH_US) * 64'(`BCS_CLK_HZ) + 64'hf423f) / 64'hf4240),
	parameter logic [`BCS_BLINK_W-1:0]    NTC_BLINK_HALF  =
		26'((64'(`BCS_CLK_HZ) * 64'h3e8) / (64'h2 * 64'(`BCS_BLINK_NTC_MHZ))),
	parameter logic [`BCS_BLINK_W-1:0]    BAD_BLINK_HALF  =
		26'((64'(`BCS_CLK_HZ) * 64'h3e8) / (64'h2 * 64'(`BCS_BLINK_BAD_MHZ)))
) (
	// clock and reset
	input  wire logic                    clk_in,
	input  wire logic                    rst_in,
	// comparator levels from the pins
	input  wire bcs_pkg::bcs_sense_t     sense_in,
	// charger off request from the serial port logic
	input  wire logic                    charger_disable_in,
	// analog loop commands
	output bcs_pkg::bcs_drive_t          charger_drive_out,
	// sequencer state
	output bcs_pkg::bcs_state_t          charge_state_out,
	// open-drain status pin
	output logic                         charge_status_output_out,
	output logic                         charge_status_output_oe_out
);

	bcs_pkg::bcs_sense_t  sense_meta;
	bcs_pkg::bcs_sense_t  sense;
	bcs_pkg::bcs_state_t  state;
	bcs_pkg::bcs_state_t  next_state;
	bcs_pkg::bcs_state_t  start_state;
	bcs_pkg::bcs_status_t status_mode;

	logic                       charge_allowed;
	logic                       charging;
	logic                       trickle_expired;
	logic                       safety_expired;
	logic                       safety_clear;
	logic                       safety_run;
	logic                       recharge_hit;
	logic                       tenth_seen;
	logic [`BCS_TIMER_W-1:0]    safety_count;
	logic [`BCS_DEGLITCH_W-1:0] recharge_count;

	// comparator pins are asynchronous to clk_in
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sense_meta <= '0;
			sense      <= '0;
		end else begin
			sense_meta <= sense_in;
			sense      <= sense_meta;
		end
	end

	// any lockout or disable ends the cycle
	assign charge_allowed = sense.vbus_ok && !charger_disable_in;
	assign charging       = (state == bcs_pkg::BCS_TRICKLE) ||
		(state == bcs_pkg::BCS_CC) || (state == bcs_pkg::BCS_CV);

	// deep discharge decided at cycle start
	assign start_state = sense.below_trickle ? bcs_pkg::BCS_TRICKLE : bcs_pkg::BCS_CC;

	always_comb begin
		next_state = state;
		if (!charge_allowed) begin
			next_state = bcs_pkg::BCS_IDLE;
		end else begin
			unique case (state)
				bcs_pkg::BCS_IDLE: begin
					next_state = start_state;
				end
				bcs_pkg::BCS_TRICKLE: begin
					if (trickle_expired) begin
						next_state = bcs_pkg::BCS_BAD;
					end else if (!sense.below_trickle) begin
						next_state = bcs_pkg::BCS_CC;
					end
				end
				bcs_pkg::BCS_CC: begin
					if (sense.at_float) begin
						next_state = bcs_pkg::BCS_CV;
					end
				end
				bcs_pkg::BCS_CV: begin
					if (safety_expired) begin
						next_state = bcs_pkg::BCS_DONE;
					end
				end
				bcs_pkg::BCS_DONE: begin
					if (recharge_hit) begin
						next_state = start_state;
					end
				end
				bcs_pkg::BCS_BAD: begin
					next_state = bcs_pkg::BCS_BAD;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state <= bcs_pkg::BCS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign charge_state_out = state;

	// trickle timer keeps counting through a temperature pause
	bcs_dwell_timer #(
		.W     (`BCS_TIMER_W),
		.LIMIT (TRKL_CYCLES)
	) u_trickle_timer (
		.clk_in      (clk_in),
		.rst_in      (rst_in),
		.clear_in    (state != bcs_pkg::BCS_TRICKLE),
		.run_in      (state == bcs_pkg::BCS_TRICKLE),
		.count_out   (),
		.expired_out (trickle_expired),
		.hit_out     ()
	);

	// cleared outside float so it starts from zero on entry
	assign safety_clear = (state != bcs_pkg::BCS_CV) || recharge_hit;
	// frozen while temperature is out of range
	assign safety_run   = (state == bcs_pkg::BCS_CV) && !sense.temp_fault;

	bcs_dwell_timer #(
		.W     (`BCS_TIMER_W),
		.LIMIT (SAFETY_CYCLES)
	) u_safety_timer (
		.clk_in      (clk_in),
		.rst_in      (rst_in),
		.clear_in    (safety_clear),
		.run_in      (safety_run),
		.count_out   (safety_count),
		.expired_out (safety_expired),
		.hit_out     ()
	);

	// dip must last the whole deglitch window
	bcs_dwell_timer #(
		.W     (`BCS_DEGLITCH_W),
		.LIMIT (DEGLITCH_CYCLES)
	) u_recharge_filter (
		.clk_in      (clk_in),
		.rst_in      (rst_in),
		.clear_in    (!sense.below_recharge),
		.run_in      (sense.below_recharge),
		.count_out   (recharge_count),
		.expired_out (),
		.hit_out     (recharge_hit)
	);

	// completion latched once seen during float
	// not while the input is current limited
	always_ff @(posedge clk_in) begin
		if (rst_in || state != bcs_pkg::BCS_CV) begin
			tenth_seen <= 1'b0;
		end else if (sense.current_tenth && !sense.input_limited) begin
			tenth_seen <= 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			charger_drive_out <= '0;
		end else begin
			charger_drive_out.charge_on       <= charging && !sense.temp_fault;
			charger_drive_out.trickle_current <= state == bcs_pkg::BCS_TRICKLE;
			charger_drive_out.voltage_mode    <= state == bcs_pkg::BCS_CV;
		end
	end

	// fault indications win over charge status
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			status_mode <= bcs_pkg::BCS_ST_RELEASED;
		end else if (state == bcs_pkg::BCS_BAD) begin
			status_mode <= bcs_pkg::BCS_ST_BAD;
		end else if (charging && sense.temp_fault) begin
			status_mode <= bcs_pkg::BCS_ST_NTC;
		end else if (charging && !tenth_seen) begin
			status_mode <= bcs_pkg::BCS_ST_CHARGING;
		end else begin
			status_mode <= bcs_pkg::BCS_ST_RELEASED;
		end
	end

	bcs_status_pwm #(
		.NTC_HALF (NTC_BLINK_HALF),
		.BAD_HALF (BAD_BLINK_HALF)
	) u_status_pwm (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.mode_in       (status_mode),
		.drive_low_out (charge_status_output_oe_out)
	);

	// pin only ever pulls low
	assign charge_status_output_out = 1'b0;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	trickle_current_a: assert property (
		(state == bcs_pkg::BCS_IDLE && charge_allowed && sense.below_trickle)
		|=> state == bcs_pkg::BCS_TRICKLE ##1 charger_drive_out.trickle_current)
		else $error("deep battery not started in trickle");

	bad_timeout_a: assert property (
		(state == bcs_pkg::BCS_TRICKLE && trickle_expired && charge_allowed)
		|=> state == bcs_pkg::BCS_BAD ##1 status_mode == bcs_pkg::BCS_ST_BAD)
		else $error("trickle timeout did not raise bad battery");

	trickle_exit_a: assert property (
		(state == bcs_pkg::BCS_TRICKLE && !sense.below_trickle && !trickle_expired
		 && charge_allowed)
		|=> state == bcs_pkg::BCS_CC ##1 !charger_drive_out.trickle_current)
		else $error("trickle not left above threshold");

	float_handover_a: assert property (
		(state == bcs_pkg::BCS_CC && sense.at_float && charge_allowed)
		|=> state == bcs_pkg::BCS_CV ##1 charger_drive_out.voltage_mode)
		else $error("float voltage did not start regulation");

	safety_start_a: assert property (
		(state == bcs_pkg::BCS_CV && $past(state) == bcs_pkg::BCS_CC)
		|-> safety_count == '0 ##1 (sense.temp_fault || $past(sense.temp_fault)
		|| safety_count != '0))
		else $error("safety timer not started from zero");

	safety_stop_a: assert property (
		(state == bcs_pkg::BCS_CV && safety_expired && charge_allowed)
		|=> state == bcs_pkg::BCS_DONE ##1 !charger_drive_out.charge_on)
		else $error("expired timer did not stop charging");

	auto_recharge_a: assert property (
		(state == bcs_pkg::BCS_DONE && recharge_hit && charge_allowed)
		|=> state inside {bcs_pkg::BCS_TRICKLE, bcs_pkg::BCS_CC})
		else $error("recharge crossing did not restart");

	timer_rewind_a: assert property (
		(state == bcs_pkg::BCS_CV && recharge_hit && !safety_expired && charge_allowed)
		|=> safety_count == '0)
		else $error("safety timer not cleared by recharge dip");

	dip_filter_a: assert property (
		$rose(recharge_hit) |-> $past(sense.below_recharge, 1)
		&& $past(sense.below_recharge, 2)
		&& $past(recharge_count) == DEGLITCH_CYCLES - 1'b1)
		else $error("recharge qualified on a short dip");

	restart_a: assert property (
		!charge_allowed |=> state == bcs_pkg::BCS_IDLE ##1 !charger_drive_out.charge_on)
		else $error("lockout or disable did not end the cycle");

	status_low_a: assert property (
		(state == bcs_pkg::BCS_CC && !sense.temp_fault)
		|=> status_mode == bcs_pkg::BCS_ST_CHARGING ##1 charge_status_output_oe_out)
		else $error("status pin not low while charging");

	done_release_a: assert property (
		(state == bcs_pkg::BCS_CV && sense.current_tenth && !sense.input_limited
		 && !sense.temp_fault && next_state == bcs_pkg::BCS_CV) ##1 !sense.temp_fault
		|=> status_mode == bcs_pkg::BCS_ST_RELEASED)
		else $error("completion did not release status pin");

	limit_mask_a: assert property (
		(state == bcs_pkg::BCS_CV && !tenth_seen && sense.input_limited)
		|=> !tenth_seen)
		else $error("completion taken during current limit");

	temp_pause_a: assert property (
		(sense.temp_fault && state == bcs_pkg::BCS_CV && !safety_clear)
		|=> $stable(safety_count) ##0 !charger_drive_out.charge_on)
		else $error("temperature fault did not pause charging");

	bad_hold_a: assert property (
		(state == bcs_pkg::BCS_BAD && charge_allowed)
		|=> state == bcs_pkg::BCS_BAD ##0 !charger_drive_out.charge_on)
		else $error("bad battery fault left without restart");

	reach_done_c: cover property (state == bcs_pkg::BCS_CV ##1 state == bcs_pkg::BCS_DONE);
	reach_bad_c: cover property (state == bcs_pkg::BCS_TRICKLE ##1 state == bcs_pkg::BCS_BAD);
	rewind_c: cover property (state == bcs_pkg::BCS_CV && recharge_hit);
	ntc_show_c: cover property (status_mode == bcs_pkg::BCS_ST_NTC);

endmodule

// ==== dv/bcs_host_model.sv ====
`timescale 1ns/10ps
module bcs_host_model (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// status pin level behind the pull-up
	input  wire logic        pin_in,
	// expected pin-low widths and statistics clear
	input  wire logic [11:0] short_len_in,
	input  wire logic [11:0] long_len_in,
	input  wire logic        clear_in,
	// pulse statistics
	output logic [15:0]      short_hits_out,
	output logic [15:0]      long_hits_out,
	output logic [15:0]      odd_hits_out
);
	logic [15:0] run;
	logic        last;
	logic        armed;

	function automatic logic near(input logic [15:0] a, input logic [15:0] b);
		return (a + 16'h3 >= b) && (a <= b + 16'h3);
	endfunction

	// a pulse is only measured from its falling edge, so a partial first pulse never counts
	always_ff @(posedge clk_in) begin
		if (rst_in || clear_in) begin
			run <= 16'h0;
			last <= 1'b0;
			armed <= 1'b0;
			short_hits_out <= 16'h0;
			long_hits_out <= 16'h0;
			odd_hits_out <= 16'h0;
		end else begin
			last <= pin_in;
			if (!pin_in) begin
				run <= run + 16'h1;
			end
			if (last && !pin_in) begin
				armed <= 1'b1;
				run <= 16'h1;
			end
			if (pin_in && !last && armed) begin
				if (near(run, {4'h0, short_len_in})) begin
					short_hits_out <= short_hits_out + 16'h1;
				end else if (near(run, {4'h0, long_len_in})) begin
					long_hits_out <= long_hits_out + 16'h1;
				end else begin
					odd_hits_out <= odd_hits_out + 16'h1;
				end
			end
		end
	end
endmodule

// ==== dv/battery_charge_sequencer_bench.sv ====
`timescale 1ns/10ps
module battery_charge_sequencer_bench;
	localparam int TRKL = 32'h28;
	localparam int SAFETY = 32'hc8;
	localparam int DEGLITCH = 32'h8;
	localparam int NTC_HALF = 32'h37cc;
	localparam int BAD_HALF = 32'h1be6;
	localparam int PWM_PERIOD = 32'hdf3;

	logic                 clk_in = 1'b0;
	logic                 rst_in = 1'b1;
	bcs_pkg::bcs_sense_t  sense = '0;
	logic                 charger_disable_in = 1'b0;
	bcs_pkg::bcs_drive_t  charger_drive_out;
	bcs_pkg::bcs_state_t  charge_state_out;
	logic                 charge_status_output_out;
	logic                 charge_status_output_oe_out;
	logic                 pin;
	logic [11:0]          short_len = 12'h0;
	logic [11:0]          long_len = 12'h0;
	logic                 meas_clear = 1'b0;
	logic [15:0]          short_hits;
	logic [15:0]          long_hits;
	logic [15:0]          odd_hits;
	int                   miscompares = 0;
	int                   num_checks = 0;
	int                   n;

	always #4 clk_in = ~clk_in;

	// pull-up on the open-drain pin
	assign pin = charge_status_output_oe_out ? charge_status_output_out : 1'b1;

	bcs_charge_sequencer #(
		.TRKL_CYCLES     (42'h28),
		.SAFETY_CYCLES   (42'hc8),
		.DEGLITCH_CYCLES (18'h8),
		.NTC_BLINK_HALF  (26'h37cc),
		.BAD_BLINK_HALF  (26'h1be6)
	) uut (
		.clk_in                      (clk_in),
		.rst_in                      (rst_in),
		.sense_in                    (sense),
		.charger_disable_in          (charger_disable_in),
		.charger_drive_out           (charger_drive_out),
		.charge_state_out            (charge_state_out),
		.charge_status_output_out    (charge_status_output_out),
		.charge_status_output_oe_out (charge_status_output_oe_out)
	);

	bcs_host_model host (
		.clk_in         (clk_in),
		.rst_in         (rst_in),
		.pin_in         (pin),
		.short_len_in   (short_len),
		.long_len_in    (long_len),
		.clear_in       (meas_clear),
		.short_hits_out (short_hits),
		.long_hits_out  (long_hits),
		.odd_hits_out   (odd_hits)
	);

	function automatic int run_len(input int k);
		return PWM_PERIOD * k / 16;
	endfunction

	task automatic end_of_test();
		if (miscompares == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic step(input int c);
		repeat (c) @(negedge clk_in);
	endtask

	task automatic cmp_state(input string what, input bcs_pkg::bcs_state_t exp);
		num_checks++;
		if (charge_state_out !== exp) begin
			$display("[FAIL] %s exp %s got %s", what, exp.name(), charge_state_out.name());
			miscompares++;
		end
	endtask

	task automatic cmp_drive(input string what, input bcs_pkg::bcs_drive_t exp);
		num_checks++;
		if (charger_drive_out !== exp) begin
			$display("[FAIL] %s exp %b got %b", what, exp, charger_drive_out);
			miscompares++;
		end
	endtask

	task automatic cmp_bit(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			$display("[FAIL] %s exp %b got %b", what, exp, got);
			miscompares++;
		end
	endtask

	// waits are bounded; running out ends the run
	task automatic wait_state(input bcs_pkg::bcs_state_t s, input int bound, output int c);
		c = 0;
		while (charge_state_out !== s && c < bound) begin
			@(negedge clk_in);
			c++;
		end
		if (charge_state_out !== s) begin
			$display("[FAIL] wait for %s exp reached got %s", s.name(), charge_state_out.name());
			miscompares++;
			end_of_test();
		end
	endtask

	// three blink halves always hold one whole half of each duty
	task automatic measure(input int k_lo, input int k_hi, input int half);
		int runs;
		int seen;
		short_len = 12'(run_len(k_lo));
		long_len = 12'(run_len(k_hi));
		meas_clear = 1'b1;
		step(1);
		meas_clear = 1'b0;
		step(3 * half);
		runs = 3 * half / PWM_PERIOD;
		seen = int'(short_hits) + int'(long_hits) + int'(odd_hits);
		cmp_bit("short pulses", 1'b1, logic'(short_hits != 16'h0));
		cmp_bit("long pulses", 1'b1, logic'(long_hits != 16'h0));
		cmp_bit("pulse rate", 1'b1, logic'(seen >= runs - 2 && seen <= runs + 1));
		cmp_bit("odd pulses", 1'b1, logic'(odd_hits <= 16'h4));
	endtask

	initial begin
		void'($urandom(32'ha3e2));
		step(12);
		rst_in = 1'b0;
		cmp_state("reset state", bcs_pkg::BCS_IDLE);
		cmp_drive("reset drive", 3'b000);
		cmp_bit("reset pin", 1'b1, pin);
		sense.vbus_ok = 1'b1;
		sense.below_trickle = 1'b1;
		wait_state(bcs_pkg::BCS_TRICKLE, 10, n);
		step(2);
		cmp_drive("trickle drive", 3'b110);
		cmp_bit("trickle pin", 1'b0, pin);
		sense.below_trickle = 1'b0;
		wait_state(bcs_pkg::BCS_CC, 10, n);
		step(2);
		cmp_drive("cc drive", 3'b100);
		cmp_bit("cc pin", 1'b0, pin);
		sense.at_float = 1'b1;
		wait_state(bcs_pkg::BCS_CV, 10, n);
		step(2);
		cmp_drive("cv drive", 3'b101);
		sense.current_tenth = 1'b1;
		sense.input_limited = 1'b1;
		step(8);
		cmp_bit("limited pin", 1'b0, pin);
		sense.input_limited = 1'b0;
		step(6);
		cmp_bit("complete pin", 1'b1, pin);
		wait_state(bcs_pkg::BCS_DONE, SAFETY + 20, n);
		cmp_bit("safety time", 1'b1, logic'(n + 16 >= SAFETY - 2 && n + 16 <= SAFETY + 6));
		step(3);
		cmp_drive("done drive", 3'b000);
		sense.current_tenth = 1'b0;
		repeat (5) begin
			sense.below_recharge = 1'b1;
			step($urandom_range(DEGLITCH - 3, 1));
			sense.below_recharge = 1'b0;
			step(4);
		end
		cmp_state("short dips", bcs_pkg::BCS_DONE);
		sense.below_recharge = 1'b1;
		wait_state(bcs_pkg::BCS_CC, DEGLITCH + 8, n);
		sense.below_recharge = 1'b0;
		cmp_bit("dip length", 1'b1, logic'(n >= DEGLITCH && n <= DEGLITCH + 6));
		wait_state(bcs_pkg::BCS_CV, 10, n);
		step($urandom_range(120, 60));
		sense.below_recharge = 1'b1;
		step(DEGLITCH + 4);
		sense.below_recharge = 1'b0;
		wait_state(bcs_pkg::BCS_DONE, SAFETY + 40, n);
		n = n + DEGLITCH + 4 - SAFETY;
		cmp_bit("timer cleared", 1'b1, logic'(n >= DEGLITCH - 2 && n <= DEGLITCH + 10));
		sense.vbus_ok = 1'b0;
		wait_state(bcs_pkg::BCS_IDLE, 6, n);
		cmp_drive("lockout drive", 3'b000);
		sense.vbus_ok = 1'b1;
		wait_state(bcs_pkg::BCS_CC, 8, n);
		wait_state(bcs_pkg::BCS_CV, 10, n);
		sense.temp_fault = 1'b1;
		step(6);
		cmp_bit("paused charge", 1'b0, charger_drive_out.charge_on);
		step(100);
		measure(1, 15, NTC_HALF);
		cmp_state("frozen timer", bcs_pkg::BCS_CV);
		sense.temp_fault = 1'b0;
		step(6);
		cmp_bit("resumed pin", 1'b0, pin);
		sense.at_float = 1'b0;
		sense.below_trickle = 1'b1;
		// levels pass two flops, the disable none: let them settle first
		step(3);
		charger_disable_in = 1'b1;
		wait_state(bcs_pkg::BCS_IDLE, 4, n);
		charger_disable_in = 1'b0;
		wait_state(bcs_pkg::BCS_TRICKLE, 8, n);
		wait_state(bcs_pkg::BCS_BAD, TRKL + 10, n);
		cmp_bit("trickle timeout", 1'b1, logic'(n >= TRKL - 2 && n <= TRKL + 4));
		step(3);
		cmp_bit("bad charge off", 1'b0, charger_drive_out.charge_on);
		step(100);
		measure(2, 14, BAD_HALF);
		sense.below_trickle = 1'b0;
		sense.at_float = 1'b1;
		step(20);
		cmp_state("bad holds", bcs_pkg::BCS_BAD);
		// host lowers the load and retries by cycling the input
		sense.at_float = 1'b0;
		sense.vbus_ok = 1'b0;
		step(4);
		sense.vbus_ok = 1'b1;
		wait_state(bcs_pkg::BCS_CC, 10, n);
		end_of_test();
	end
endmodule
